// ==== rtl/ecc_pkg.sv ====
// Constants and types for the EDAC host controller
package ecc_pkg;

  // ==========================================================================
  // APB register map (byte offsets)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_WDATA    = 8'h04;
  localparam logic [7:0] REG_RDATA    = 8'h08;
  localparam logic [7:0] REG_CHECK    = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_INT_STAT = 8'h14;
  localparam logic [7:0] REG_INT_MASK = 8'h18;

  // CTRL fields (write-only command pulses)
  localparam int CTRL_START_WR = 0;
  localparam int CTRL_START_RD = 1;

  // STATUS fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_SINGLE = 1;
  localparam int STAT_DOUBLE = 2;

  // Interrupt status and mask fields
  localparam int INT_DONE    = 0;
  localparam int INT_CORR    = 1;
  localparam int INT_UNCORR  = 2;
  localparam int INT_W       = 3;

  // ==========================================================================
  // Device mode select codes, {first select, second select}
  // ==========================================================================
  localparam logic [1:0] MODE_WRITE   = 2'h0;
  localparam logic [1:0] MODE_READ    = 2'h1;
  localparam logic [1:0] MODE_LATCH   = 2'h3;
  localparam logic [1:0] MODE_CORRECT = 2'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SETTLE_NS   = 200;
  localparam int SETTLE_CYC    =
    (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int DATA_W  = 16;
  localparam int CHECK_W = 6;

  // ==========================================================================
  // Sequencer states, Gray coded along idle-read-latch-correct
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_READ    = 3'h1,
    ST_LATCH   = 3'h3,
    ST_CORRECT = 3'h2,
    ST_WRITE   = 3'h4
  } ecc_state_t;

endpackage

// ==== rtl/ecc_host.sv ====
// EDAC host controller: APB registers driving the EDAC device pins
//
// Contract
// - Write mode: host drives data, device drives check bits, flags low.
// - Read mode takes memory word; host latches before testing flags.
// - Correct mode: device drives corrected data and 6-bit syndrome.
// - Single check-bit error: host still runs the correction cycle.
`timescale 1ns/10ps

module ecc_host
  import ecc_pkg::*;
#(
  parameter logic [3:0] SETTLE = 4'(ecc_pkg::SETTLE_CYC)
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic      [1:0]                   mode_select,
  input  wire logic [ecc_pkg::DATA_W-1:0]   data_in,
  output logic      [ecc_pkg::DATA_W-1:0]   data_out,
  output logic                              data_oe,
  input  wire logic [ecc_pkg::CHECK_W-1:0]  check_in,
  input  wire logic                         single_error_flag,
  input  wire logic                         double_error_flag,
  output logic                              irq
);

  import ecc_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ecc_state_t          st;
    logic [3:0]          cnt;
    logic [1:0]          mode;
    logic [DATA_W-1:0]   dout;
    logic                doe;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic [CHECK_W-1:0]  check;
    logic                sgl_err;
    logic                dbl_err;
    logic [INT_W-1:0]    ist;
    logic [INT_W-1:0]    imask;
  } ecc_host_t;

  localparam ecc_host_t RESET_Q = '{
    st:    ST_IDLE,
    cnt:   4'h0,
    mode:  MODE_READ,
    dout:  16'h0000,
    doe:   1'b0,
    wdata: 16'h0000,
    rdata: 16'h0000,
    check: 6'h00,
    sgl_err: 1'b0,
    dbl_err: 1'b0,
    ist:   3'h0,
    imask: 3'h0
  };

  logic [1:0] rst_sync_q;
  logic       rst_s_n;
  ecc_host_t  q;
  ecc_host_t  d;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_s_n = rst_sync_q[1];

  // ==========================================================================
  // APB decode
  // ==========================================================================
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == REG_CTRL) || (a == REG_WDATA) || (a == REG_RDATA) ||
                 (a == REG_CHECK) || (a == REG_STATUS) ||
                 (a == REG_INT_STAT) || (a == REG_INT_MASK);
  endfunction

  logic apb_acc;
  logic apb_wr;
  logic settle_done;

  assign apb_acc     = psel && penable;
  assign apb_wr      = apb_acc && pwrite && addr_known(paddr);
  assign pready      = 1'b1;
  assign pslverr     = apb_acc && !addr_known(paddr);
  assign settle_done = (q.cnt == 4'h0);

  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_acc && !pwrite) begin
      unique case (paddr)
        REG_WDATA:    prdata = {16'h0000, q.wdata};
        REG_RDATA:    prdata = {16'h0000, q.rdata};
        REG_CHECK:    prdata = {26'h0000000, q.check};
        REG_STATUS:   prdata = {29'h00000000, q.dbl_err, q.sgl_err,
                                (q.st != ST_IDLE)};
        REG_INT_STAT: prdata = {29'h00000000, q.ist};
        REG_INT_MASK: prdata = {29'h00000000, q.imask};
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer and registers
  // ==========================================================================
  logic [INT_W-1:0] evt;

  always_comb begin
    d   = q;
    evt = 3'h0;
    if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
    end
    if (apb_wr && (paddr == REG_WDATA)) begin
      d.wdata = pwdata[DATA_W-1:0];
    end
    if (apb_wr && (paddr == REG_INT_MASK)) begin
      d.imask = pwdata[INT_W-1:0];
    end
    unique case (q.st)
      ST_IDLE: begin
        if (apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_START_WR]) begin
          d.st   = ST_WRITE;
          d.mode = MODE_WRITE;
          d.dout = q.wdata;
          d.doe  = 1'b1;
          d.cnt  = SETTLE - 4'h1;
        end else if (apb_wr && (paddr == REG_CTRL) &&
                     pwdata[CTRL_START_RD]) begin
          d.st   = ST_READ;
          d.mode = MODE_READ;
          d.cnt  = SETTLE - 4'h1;
        end
      end
      ST_WRITE: begin
        if (settle_done) begin
          d.check = check_in;
          d.sgl_err = 1'b0;
          d.dbl_err = 1'b0;
          d.doe   = 1'b0;
          d.mode  = MODE_READ;
          d.st    = ST_IDLE;
          evt[INT_DONE] = 1'b1;
        end
      end
      ST_READ: begin
        if (settle_done) begin
          d.rdata = data_in;
          d.check = check_in;
          d.mode  = MODE_LATCH;
          d.st    = ST_LATCH;
          d.cnt   = SETTLE - 4'h1;
        end
      end
      ST_LATCH: begin
        if (settle_done) begin
          d.sgl_err = single_error_flag;
          d.dbl_err = double_error_flag;
          if (double_error_flag) begin
            d.mode = MODE_READ;
            d.st   = ST_IDLE;
            evt[INT_UNCORR] = 1'b1;
            evt[INT_DONE]   = 1'b1;
          end else if (single_error_flag) begin
            d.mode = MODE_CORRECT;
            d.st   = ST_CORRECT;
            d.cnt  = SETTLE - 4'h1;
          end else begin
            d.mode = MODE_READ;
            d.st   = ST_IDLE;
            evt[INT_DONE] = 1'b1;
          end
        end
      end
      ST_CORRECT: begin
        if (settle_done) begin
          d.rdata = data_in;
          d.check = check_in;
          d.mode  = MODE_READ;
          d.st    = ST_IDLE;
          evt[INT_CORR] = 1'b1;
          evt[INT_DONE] = 1'b1;
        end
      end
    endcase
    // Sticky interrupt bits; a new event wins over a write-one clear
    if (apb_wr && (paddr == REG_INT_STAT)) begin
      d.ist = (q.ist & ~pwdata[INT_W-1:0]) | evt;
    end else begin
      d.ist = q.ist | evt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      q <= RESET_Q;
    end else begin
      q <= d;
    end
  end

  assign mode_select = q.mode;
  assign data_out    = q.dout;
  assign data_oe     = q.doe;
  assign irq         = |(q.ist & q.imask);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_latch_single;
    (q.st == ST_LATCH) && settle_done && single_error_flag &&
      !double_error_flag;
  endsequence

  sequence s_enter_correct;
    (q.st == ST_CORRECT) && (mode_select == MODE_CORRECT) &&
      (q.cnt == SETTLE - 4'h1);
  endsequence

  sequence s_read_done;
    (q.st == ST_READ) && settle_done;
  endsequence

  a_write_drives_data: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    (q.st == ST_WRITE) |-> (data_oe && (mode_select == MODE_WRITE) &&
                            (data_out == q.wdata)))
    else $error("write cycle without driven data in write mode");

  a_no_drive_else: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    (mode_select != MODE_WRITE) |-> !data_oe)
    else $error("data driven outside write mode");

  a_write_check_cap: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    ((q.st == ST_WRITE) && settle_done) |=>
      ((q.check == $past(check_in)) && (q.st == ST_IDLE) && q.ist[INT_DONE]))
    else $error("check word not captured at end of write");

  a_read_then_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    s_read_done |=> ((q.st == ST_LATCH) && (mode_select == MODE_LATCH) &&
                     (q.rdata == $past(data_in))))
    else $error("latch step did not follow read step");

  a_flags_after_latch: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    $rose(q.sgl_err) |-> ($past(q.st) == ST_LATCH) &&
                     ($past(mode_select) == MODE_LATCH))
    else $error("error flags sampled outside latch mode");

  a_single_corrects: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    s_latch_single |=> s_enter_correct)
    else $error("single error not sent through correction");

  a_double_uncorr: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    ((q.st == ST_LATCH) && settle_done && double_error_flag) |=>
      (q.ist[INT_UNCORR] && (q.st == ST_IDLE) &&
       (!q.ist[INT_CORR] || $past(q.ist[INT_CORR]))))
    else $error("double error did not raise uncorrectable status");

  a_correct_capture: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    ((q.st == ST_CORRECT) && settle_done) |=>
      ((q.rdata == $past(data_in)) && (q.check == $past(check_in)) &&
       q.ist[INT_CORR] && (mode_select == MODE_READ)))
    else $error("corrected data or syndrome not captured");

  a_irq_follows: assert property (
    @(posedge ref_clk) disable iff (!rst_s_n)
    (evt[INT_UNCORR] && d.imask[INT_UNCORR]) |=> irq)
    else $error("unmasked uncorrectable event did not raise irq");

endmodule // ecc_host

// ==== verif/ecc_ref_pkg.sv ====
// Parity group tables shared by the device model and the bench
package ecc_ref_pkg;

  // ====================
  // Parity groups
  // ====================
  localparam logic [15:0] GRP [6] = '{16'h271B, 16'h496D, 16'h92B6,
                                      16'h1CC7, 16'hE0F8, 16'hFF00};

  function automatic logic [5:0] gen(input logic [15:0] d);
    for (int k = 0; k < 6; k++) gen[k] = ^(d & GRP[k]);
    gen[1:0] = ~gen[1:0];
  endfunction

  function automatic logic [5:0] col(input int i);
    for (int k = 0; k < 6; k++) col[k] = GRP[k][i];
  endfunction

endpackage

// ==== verif/ecc_edac_model.sv ====
// Behavioural EDAC device together with its stored memory word
`timescale 1ns/10ps

module ecc_edac_model
  import ecc_ref_pkg::*;
(
  input  wire logic [1:0]  mode_select,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic [15:0] flip_d,
  input  wire logic [5:0]  flip_c,
  output logic      [15:0] data_in,
  output logic      [5:0]  check_in,
  output logic             single_error_flag,
  output logic             double_error_flag
);
  logic [15:0] mem_d = 16'h0, lat_d = 16'h0, fix, last = 16'h0;
  logic [5:0]  mem_c = 6'h0, lat_c = 6'h0, syn;

  // ====================
  // Memory and latches
  // ====================
  always @* if (mode_select == 2'h0 && data_oe) begin
    mem_d = data_out;
    mem_c = gen(data_out);
  end

  always @(mode_select) if (mode_select == 2'h3) begin
    lat_d = mem_d ^ flip_d;
    lat_c = mem_c ^ flip_c;
  end

  // Undriven bus shows the inverse of its last driven value
  always @(data_in) if (data_oe || mode_select != 2'h0) last = data_in;

  // ====================
  // Check, flags, correction
  // ====================
  always_comb begin
    syn = ~(gen(lat_d) ^ lat_c);
    fix = 16'h0;
    for (int i = 0; i < 16; i++)
      if (~syn == col(i)) fix[i] = 1'b1;
    single_error_flag = mode_select[1] && syn != 6'h3F;
    double_error_flag = single_error_flag && !(^syn);
    case (mode_select)
      2'h0: data_in = data_oe ? data_out : ~last;
      2'h2: data_in = data_oe ? 16'hXXXX : lat_d ^ fix;
      default: data_in = data_oe ? 16'hXXXX : mem_d ^ flip_d;
    endcase
    check_in = mode_select == 2'h2 ? syn : mem_c ^ flip_c;
    if (mode_select == 2'h0) check_in = gen(data_in);
  end

endmodule // ecc_edac_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the EDAC host controller
`timescale 1ns/10ps

module tb_top;
  import ecc_pkg::*;
  import ecc_ref_pkg::*;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, data_oe, irq, err;
  logic        single_error_flag, double_error_flag;
  logic [1:0]  mode_select;
  logic [15:0] data_in, data_out, flip_d = 16'h0;
  logic [5:0]  check_in, flip_c = 6'h0;
  int          failures = 0, total_checks = 0, cyc = 0;

  always #50 ref_clk = ~ref_clk;

  ecc_host #(.SETTLE(4'h2)) ecc_host_i (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_select,
    .data_in, .data_out, .data_oe, .check_in, .single_error_flag,
    .double_error_flag, .irq);

  ecc_edac_model ecc_edac_model_i (.mode_select, .data_out, .data_oe,
    .flip_d, .flip_c, .data_in, .check_in, .single_error_flag,
    .double_error_flag);

  // ====================
  // Shared tasks
  // ====================
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done;
    int n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 100);
    if (rd[STAT_BUSY] !== 1'b0) chk("busy", 32'h0, {31'h0, rd[STAT_BUSY]});
  endtask

  task automatic op(input logic [15:0] x, fd, input logic [5:0] fc);
    flip_d <= 16'h0;
    flip_c <= 6'h0;
    apb(1'b1, REG_WDATA, {16'h0, x});
    apb(1'b1, REG_CTRL, 32'h1);
    wait_done;
    flip_d <= fd;
    flip_c <= fc;
    apb(1'b1, REG_CTRL, 32'h2);
    wait_done;
  endtask

  task automatic res(input logic [15:0] d, input logic [5:0] c,
                     input logic [2:0] st, is);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("rdata", {16'h0, d}, rd);
    apb(1'b0, REG_CHECK, 32'h0);
    chk("check", {26'h0, c}, rd);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", {29'h0, st}, rd);
    apb(1'b0, REG_INT_STAT, 32'h0);
    chk("int_stat", {29'h0, is}, rd);
    apb(1'b1, REG_INT_STAT, 32'h7);
    #1;
    chk("irq_clear", 32'h0, {31'h0, irq});
  endtask

  // ====================
  // Scenarios
  // ====================
  task automatic t_reset;
    chk("rst_mode", 32'h1, {30'h0, mode_select});
    chk("rst_irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, REG_INT_MASK, 32'h7);
  endtask

  task automatic t_write;
    logic [15:0] v [3] = '{16'h0000, 16'hFFFF, 16'hA5C3};
    logic [5:0]  e [3] = '{6'h03, 6'h03, gen(16'hA5C3)};
    foreach (v[i]) begin
      apb(1'b1, REG_WDATA, {16'h0, v[i]});
      apb(1'b1, REG_CTRL, 32'h1);
      @(posedge ref_clk);
      #1;
      chk("wr_mode", 32'h0, {30'h0, mode_select});
      chk("wr_data", {16'h0, v[i]}, {16'h0, data_in});
      wait_done;
      apb(1'b0, REG_CHECK, 32'h0);
      chk("wr_check", {26'h0, e[i]}, rd);
      chk("irq_done", 32'h1, {31'h0, irq});
      // Writes leave the read data register untouched
      res(16'h0000, e[i], 3'h0, 3'h1);
    end
  endtask

  task automatic t_clean;
    op(16'h3C96, 16'h0, 6'h0);
    res(16'h3C96, gen(16'h3C96), 3'h0, 3'h1);
  endtask

  task automatic t_data1;
    for (int i = 0; i < 16; i++) begin
      op(16'h5A3C, 16'h1 << i, 6'h0);
      res(16'h5A3C, ~col(i), 3'h2, 3'h3);
    end
  endtask

  task automatic t_check1;
    for (int k = 0; k < 6; k++) begin
      op(16'hC3A5, 16'h0, 6'h1 << k);
      res(16'hC3A5, ~(6'h1 << k), 3'h2, 3'h3);
    end
  endtask

  // At most two flips, bar the gross all-low/all-high words
  task automatic t_double;
    logic [15:0] fd [5] = '{16'h0011, 16'h0, 16'h0100, 16'h0, 16'hFFFF};
    logic [5:0]  fc [5] = '{6'h0, 6'h21, 6'h04, 6'h03, 6'h3C};
    logic [15:0] x [5] = '{16'h1234, 16'h1234, 16'h1234, 16'h0, 16'h0};
    foreach (fd[i]) begin
      op(x[i], fd[i], fc[i]);
      res(x[i] ^ fd[i], gen(x[i]) ^ fc[i], 3'h6, 3'h5);
    end
  endtask

  task automatic t_mask;
    apb(1'b1, REG_INT_MASK, 32'h4);
    op(16'h0F0F, 16'h0004, 6'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, REG_INT_MASK, 32'h7);
    #1;
    chk("irq_unmask", 32'h1, {31'h0, irq});
    res(16'h0F0F, ~col(2), 3'h2, 3'h3);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_write;
    t_clean;
    t_data1;
    t_check1;
    t_double;
    t_mask;
    stop_test;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      stop_test;
    end
  end

endmodule // tb_top
